// ---- logic/iod_regs.svh ----
// Constants for the indexed offset operand decoder: opcode fields,
// ranges and phase counts.
// Assumes inclusion by bare name from the design and bench files.
`ifndef IOD_REGS_SVH
`define IOD_REGS_SVH
`define IOD_OFS_LIMIT    8'h5F
`define IOD_OP_ADD_HI    6'b0010_01
`define IOD_OP_BSET_HI   4'b1000
`define IOD_OP_FILL_HI   8'b0110_1000
`define IOD_FILL_VALUE   8'hFF
`define IOD_ACC_RESET    8'h00
`define IOD_FLAG_N       4
`define IOD_FLAG_OV      3
`define IOD_FLAG_Z       2
`define IOD_FLAG_DC      1
`define IOD_FLAG_C       0
`define IOD_PHASES       4
`endif

// ---- logic/iod_pkg.sv ----
// Types shared by the indexed offset operand decoder files.
// Assumes nothing of its surroundings.
package iod_pkg;
	// Instruction classes recognised by the decoder.
	typedef enum logic [1:0] {
		IOD_OP_NONE = 2'b00,
		IOD_OP_ADD  = 2'b01,
		IOD_OP_BSET = 2'b10,
		IOD_OP_FILL = 2'b11
	} iod_op_t;
	// Four phases of one instruction cycle.
	typedef enum logic [1:0] {
		IOD_Q1 = 2'b00,
		IOD_Q2 = 2'b01,
		IOD_Q3 = 2'b10,
		IOD_Q4 = 2'b11
	} iod_phase_t;
endpackage

// ---- logic/iod_addr_gen.sv ----
// Effective data address former for byte and bit operands.
// Assumes a 12-bit data space and an 8-bit register field in the opcode.
`timescale 1ns/1ns
`include "iod_regs.svh"
module iod_addr_gen
	import iod_pkg::*;
(
	input  wire logic        ext_en_i,
	input  wire logic        access_sel_i,
	input  wire logic [7:0]  reg_field_i,
	input  wire logic [3:0]  bank_select_register_i,
	input  wire logic [11:0] stack_frame_pointer_i,
	output logic      [11:0] addr_o,
	output logic             indexed_o
);
	// =========================================================
	// Address selection
	// offset from pointer
	assign indexed_o = ext_en_i && !access_sel_i
		&& (reg_field_i <= `IOD_OFS_LIMIT);
	wire logic [11:0] idx_addr;
	wire logic [11:0] acc_addr;
	wire logic [11:0] bank_addr;
	assign idx_addr = stack_frame_pointer_i + {4'h0, reg_field_i};
	assign acc_addr = reg_field_i[7] ? {4'hF, reg_field_i}
		: {4'h0, reg_field_i};
	assign bank_addr = {bank_select_register_i, reg_field_i};
	assign addr_o = indexed_o ? idx_addr
		: (access_sel_i ? bank_addr : acc_addr);
endmodule

// ---- logic/iod_core.sv ----
// Decode and execute unit for indexed literal offset operands.
// Assumes a single-port data memory whose read data is valid in the same
// cycle the address is presented, and a one-cycle issue strobe.
`timescale 1ns/1ns
`include "iod_regs.svh"
module iod_core
	import iod_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input  wire logic              core_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              extension_enable_fuse_i,
	input  wire logic              issue_i,
	input  wire logic [15:0]       opcode_i,
	input  wire logic [ADDR_W-1:0] stack_frame_pointer_i,
	input  wire logic [3:0]        bank_select_register_i,
	input  wire logic [7:0]        mem_rdata_i,
	output logic      [ADDR_W-1:0] mem_addr_o,
	output logic                   mem_we_o,
	output logic      [7:0]        mem_wdata_o,
	output logic      [7:0]        acc_o,
	output logic      [4:0]        status_o,
	output logic                   busy_o,
	output logic                   done_o,
	output logic                   illegal_o
);
	// Only a 12-bit data space is served by the address former.
	if (ADDR_W != 12) begin : g_bad_addr_w
		$error("ADDR_W must be 12");
	end

	// =========================================================
	// Decode
	// add pattern match
	wire logic is_add;
	wire logic is_bset;
	wire logic is_fill;
	assign is_add  = opcode_i[15:10] == `IOD_OP_ADD_HI && !opcode_i[8];
	assign is_bset = opcode_i[15:12] == `IOD_OP_BSET_HI && !opcode_i[8];
	assign is_fill = opcode_i[15:8] == `IOD_OP_FILL_HI;
	wire logic ext_ok;
	wire logic addr_idx;
	wire logic [11:0] ea;
	assign ext_ok = extension_enable_fuse_i;
	iod_addr_gen u_addr (
		.ext_en_i               (ext_ok),
		.access_sel_i           (opcode_i[8]),
		.reg_field_i            (opcode_i[7:0]),
		.bank_select_register_i (bank_select_register_i),
		.stack_frame_pointer_i  (stack_frame_pointer_i),
		.addr_o                 (ea),
		.indexed_o              (addr_idx)
	);
	wire iod_op_t dec_op;
	assign dec_op = !(ext_ok && addr_idx) ? IOD_OP_NONE
		: is_add ? IOD_OP_ADD : is_bset ? IOD_OP_BSET
		: is_fill ? IOD_OP_FILL : IOD_OP_NONE;

	// =========================================================
	// Phase sequencer and latched instruction
	iod_phase_t phase;
	iod_op_t    op;
	logic       dsel;
	logic [2:0] bpos;
	logic [7:0] opnd;
	logic       active;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase  <= IOD_Q1;
			active <= 1'b0;
			op     <= IOD_OP_NONE;
			dsel   <= 1'b0;
			bpos   <= 3'h0;
			mem_addr_o <= '0;
		end else if (!active) begin
			if (issue_i && dec_op != IOD_OP_NONE) begin
				active <= 1'b1;
				phase  <= IOD_Q2;
				op     <= dec_op;
				dsel   <= opcode_i[9];
				bpos   <= opcode_i[11:9];
				mem_addr_o <= ea;
			end
		end else begin
			case (phase)
				IOD_Q2:  phase <= IOD_Q3;
				IOD_Q3:  phase <= IOD_Q4;
				IOD_Q4: begin
					phase  <= IOD_Q1;
					active <= 1'b0;
				end
				default: phase <= IOD_Q1;
			endcase
		end
	end

	// Operand captured at the end of Q2, once the memory read has settled.
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			opnd <= 8'h00;
		end else if (active && phase == IOD_Q2) begin
			opnd <= mem_rdata_i;
		end
	end

	// =========================================================
	// Arithmetic
	function automatic logic [4:0] add_flags(input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] s;
		logic [4:0] lo;
		logic [4:0] f;
		s  = {1'b0, a} + {1'b0, b};
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		f  = 5'h00;
		f[`IOD_FLAG_C]  = s[8];
		f[`IOD_FLAG_DC] = lo[4];
		f[`IOD_FLAG_Z]  = s[7:0] == 8'h00;
		f[`IOD_FLAG_OV] = (a[7] == b[7]) && (s[7] != a[7]);
		f[`IOD_FLAG_N]  = s[7];
		return f;
	endfunction

	wire logic [7:0] sum;
	wire logic [7:0] bset_val;
	wire logic [7:0] result;
	assign sum = acc_o + opnd;
	assign bset_val = opnd | (8'h01 << bpos);
	assign result = (op == IOD_OP_ADD) ? sum
		: (op == IOD_OP_BSET) ? bset_val : `IOD_FILL_VALUE;
	wire logic q4_go;
	assign q4_go = active && phase == IOD_Q3;

	// =========================================================
	// Destination write in Q4
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mem_we_o    <= 1'b0;
			mem_wdata_o <= 8'h00;
			acc_o       <= `IOD_ACC_RESET;
			status_o    <= 5'h00;
		end else begin
			mem_we_o    <= q4_go && !(op == IOD_OP_ADD && !dsel);
			mem_wdata_o <= q4_go ? result : mem_wdata_o;
			if (q4_go && op == IOD_OP_ADD && !dsel) begin
				acc_o <= sum;
			end
			if (q4_go && op == IOD_OP_ADD) begin
				status_o <= add_flags(acc_o, opnd);
			end
		end
	end

	// Handshake outputs.
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_o    <= 1'b0;
			done_o    <= 1'b0;
			illegal_o <= 1'b0;
		end else begin
			busy_o    <= active ? !(phase == IOD_Q4)
				: (issue_i && dec_op != IOD_OP_NONE);
			done_o    <= q4_go;
			illegal_o <= !active && issue_i && dec_op == IOD_OP_NONE;
		end
	end

	// =========================================================
	// Assertions
	property p_start_to_done;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(!active && issue_i && dec_op != IOD_OP_NONE) |-> ##3 done_o;
	endproperty
	a_start_to_done: assert property (p_start_to_done)
		else $error("instruction did not finish in four phases");

	property p_fuse_off;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(!active && issue_i && !extension_enable_fuse_i) |=> !busy_o;
	endproperty
	a_fuse_off: assert property (p_fuse_off)
		else $error("extended op started with fuse low");

	property p_add_acc;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(q4_go && op == IOD_OP_ADD && !dsel)
		|=> acc_o == $past(sum) && !mem_we_o;
	endproperty
	a_add_acc: assert property (p_add_acc)
		else $error("add to accumulator misdirected");

	property p_add_mem;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(q4_go && op == IOD_OP_ADD && dsel)
		|=> mem_we_o && mem_wdata_o == $past(sum);
	endproperty
	a_add_mem: assert property (p_add_mem)
		else $error("add to memory misdirected");

	property p_flags_kept;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(q4_go && op != IOD_OP_ADD) |=> $stable(status_o);
	endproperty
	a_flags_kept: assert property (p_flags_kept)
		else $error("bit set or fill changed flags");

	property p_fill;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(q4_go && op == IOD_OP_FILL) |=> mem_we_o && mem_wdata_o == 8'hFF;
	endproperty
	a_fill: assert property (p_fill)
		else $error("fill did not write all ones");

	property p_zero_flag;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(q4_go && op == IOD_OP_ADD)
		|=> status_o[`IOD_FLAG_Z] == ($past(sum) == 8'h00);
	endproperty
	a_zero_flag: assert property (p_zero_flag)
		else $error("zero flag wrong after add");

	property p_index_addr;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(!active && issue_i && dec_op != IOD_OP_NONE)
		|=> mem_addr_o == $past(stack_frame_pointer_i)
			+ {4'h0, $past(opcode_i[7:0])};
	endproperty
	a_index_addr: assert property (p_index_addr)
		else $error("indexed address not pointer plus offset");

	property p_high_ofs;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(!active && issue_i && opcode_i[7:0] > 8'h5F) |=> !busy_o;
	endproperty
	a_high_ofs: assert property (p_high_ofs)
		else $error("offset above limit treated as indexed");

	c_add_w: cover property (@(posedge core_clk_i)
		q4_go && op == IOD_OP_ADD && !dsel);
	c_add_f: cover property (@(posedge core_clk_i)
		q4_go && op == IOD_OP_ADD && dsel);
	c_bset: cover property (@(posedge core_clk_i)
		q4_go && op == IOD_OP_BSET);
	c_fill: cover property (@(posedge core_clk_i)
		q4_go && op == IOD_OP_FILL);
endmodule

// ---- test/iod_core_bench.sv ----
// Self-checking bench for the indexed offset decode and execute unit.
// Assumes the unit shows done two clocks after taking an issue, reads memory
// through a combinational array held here.
`timescale 1ns/1ns
`include "iod_regs.svh"
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
	error_cnt++; $display("BAD %s exp=%h got=%h", nm, ex, gt); end end
module iod_core_bench
	import iod_pkg::*;
;
	logic        core_clk_i;
	logic        rst_b_i;
	logic        fuse;
	logic        issue_i;
	logic [15:0] opcode_i;
	logic [11:0] ptr;
	logic [3:0]  bank_select_register;
	logic [7:0]  mem [0:4095];
	logic [11:0] mem_addr_o;
	logic        mem_we_o;
	logic [7:0]  mem_wdata_o;
	logic [7:0]  acc_o;
	logic [4:0]  status_o;
	logic        busy_o;
	logic        done_o;
	logic        illegal_o;
	logic [7:0]  exp_acc;
	logic [4:0]  exp_st;
	int          error_cnt;
	int          num_checks;
	int          seed;

	iod_core #(.ADDR_W(12)) i_dut (
		.core_clk_i             (core_clk_i),
		.rst_b_i                (rst_b_i),
		.extension_enable_fuse_i(fuse),
		.issue_i                (issue_i),
		.opcode_i               (opcode_i),
		.stack_frame_pointer_i  (ptr),
		.bank_select_register_i (bank_select_register),
		.mem_rdata_i            (mem[mem_addr_o]),
		.mem_addr_o             (mem_addr_o),
		.mem_we_o               (mem_we_o),
		.mem_wdata_o            (mem_wdata_o),
		.acc_o                  (acc_o),
		.status_o               (status_o),
		.busy_o                 (busy_o),
		.done_o                 (done_o),
		.illegal_o              (illegal_o)
	);

	// ==========================================================
	// Clock, verdict and watchdog.
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// The run needs under 1500 cycles; a hang is cut well past that.
	initial begin
		repeat (20000) @(posedge core_clk_i);
		error_cnt++;
		print_verdict();
	end

	// ==========================================================
	// One instruction, predicted here and compared after issue and after done.
	// A poke raises issue again while busy; it must be ignored.
	task automatic run_op(input logic [15:0] opc, input logic fu,
		input logic [11:0] pt, input logic poke);
		logic [11:0] addr;
		logic [8:0]  sum;
		logic [4:0]  lo;
		logic [7:0]  old;
		logic [7:0]  res;
		logic        ok;
		logic        we;
		logic        add;
		addr = pt + {4'h0, opc[7:0]};
		old = mem[addr];
		add = opc[15:10] == `IOD_OP_ADD_HI && !opc[8];
		ok = fu && opc[7:0] <= `IOD_OFS_LIMIT && (add || opc[8:0] < 9'h60
			&& (opc[15:12] == `IOD_OP_BSET_HI
			|| opc[15:8] == `IOD_OP_FILL_HI));
		sum = exp_acc + old;
		lo = exp_acc[3:0] + old[3:0];
		we = !add || opc[9];
		res = add ? sum[7:0] : opc[15:12] == `IOD_OP_BSET_HI ?
			old | (8'h01 << opc[11:9]) : `IOD_FILL_VALUE;
		@(posedge core_clk_i);
		issue_i <= 1'b1;
		opcode_i <= opc;
		fuse <= fu;
		ptr <= pt;
		bank_select_register <= 4'($random(seed));
		@(posedge core_clk_i);
		issue_i <= poke && ok;
		opcode_i <= 16'h6800;
		#1;
		`CHK("busy", ok, busy_o)
		`CHK("illegal", !ok, illegal_o)
		if (ok) `CHK("addr", addr, mem_addr_o)
		@(posedge core_clk_i);
		issue_i <= 1'b0;
		repeat (1) @(posedge core_clk_i);
		#1;
		`CHK("done", ok, done_o)
		`CHK("we", ok && we, mem_we_o)
		if (ok && we) `CHK("wdata", res, mem_wdata_o)
		if (ok && add) begin
			exp_st = {res[7], exp_acc[7] == old[7] && res[7] != old[7],
				res == 8'h00, lo[4], sum[8]};
			if (!opc[9]) exp_acc = res;
		end
		if (ok && we) mem[addr] = res;
		`CHK("acc", exp_acc, acc_o)
		`CHK("status", exp_st, status_o)
	endtask

	// ==========================================================
	// Reset, corner cases, then random traffic.
	logic [15:0] corner [0:8] = '{16'h2400, 16'h265F, 16'h8E0A,
		16'h805F, 16'h682C, 16'h2460, 16'h2500, 16'hF000, 16'h6960};
	initial begin
		seed = 91;
		error_cnt = 0;
		num_checks = 0;
		rst_b_i = 1'b0;
		fuse = 1'b1;
		issue_i = 1'b0;
		opcode_i = 16'h0000;
		ptr = 12'h000;
		bank_select_register = 4'h0;
		exp_acc = `IOD_ACC_RESET;
		exp_st = 5'h00;
		for (int i = 0; i < 4096; i++) mem[i] = 8'($random(seed));
		repeat (5) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		#1;
		`CHK("acc reset", 8'h00, acc_o)
		`CHK("busy reset", 1'b0, busy_o)
		$display("test reset done");
		for (int i = 0; i < 9; i++) run_op(corner[i], 1'b1, 12'hA00, 1'b0);
		for (int i = 0; i < 5; i++) run_op(corner[i], 1'b0, 12'hFA0, 1'b0);
		for (int i = 0; i < 5; i++) run_op(corner[i], 1'b1, 12'hFA0, 1'b1);
		$display("test corners done");
		for (int i = 0; i < 200; i++) begin
			logic [7:0]  k;
			logic [15:0] op;
			k = 8'($unsigned($random(seed)) % 98);
			op = 16'($random(seed));
			case ($unsigned($random(seed)) % 4)
				0: op = {6'b0010_01, op[9], 1'b0, k};
				1: op = {4'b1000, op[11:9], 1'b0, k};
				2: op = {8'h68, k};
				default: ;
			endcase
			run_op(op, ($random(seed) & 15) != 0,
				12'($random(seed)) & 12'hEFF, ($random(seed) & 3) == 0);
		end
		$display("test random done");
		print_verdict();
	end
endmodule
